//--- logic/rsy_regs.svh
`ifndef RSY_REGS_SVH
`define RSY_REGS_SVH

// ==========================================================
// I/O offsets
`define RSY_OFF_MEM_CFG     8'h22
`define RSY_OFF_ROLL_ONE    8'h24
`define RSY_OFF_ROLL_TWO    8'h26
`define RSY_OFF_REGION_ZERO 8'h28
`define RSY_OFF_REGION_ONE  8'h2a
`define RSY_OFF_GRAN_EN     8'h2c
`define RSY_OFF_EXT_GRAN    8'h2e
`define RSY_OFF_PARITY      8'h61

// ==========================================================
// Register indices in the storage array
`define RSY_IDX_MEM_CFG     3'h0
`define RSY_IDX_ROLL_ONE    3'h1
`define RSY_IDX_ROLL_TWO    3'h2
`define RSY_IDX_REGION_ZERO 3'h3
`define RSY_IDX_REGION_ONE  3'h4
`define RSY_IDX_GRAN_EN     3'h5
`define RSY_IDX_EXT_GRAN    3'h6
`define RSY_NUM_REGS        7

// ==========================================================
// Values after system reset (undefined bits taken as zero)
`define RSY_RST_MEM_CFG     16'h0000
`define RSY_RST_ROLL_ONE    16'h0000
`define RSY_RST_ROLL_TWO    16'h0000
`define RSY_RST_REGION_ZERO 16'h00f9
`define RSY_RST_REGION_ONE  16'h0000
`define RSY_RST_GRAN_EN     16'h0000
`define RSY_RST_EXT_GRAN    16'h0000
`define RSY_RST_PARITY      1'h0

// ==========================================================
// Field positions and timing
`define RSY_PARITY_BIT      2
`define RSY_SYNC_STAGES     2
`define RSY_HOLD_CPU_MIN    16
`define RSY_HOLD_SELFTEST   80

`endif

//--- logic/rsy_pkg.sv
`default_nettype none

package rsy_pkg;

   // Sequencer states
   typedef enum logic [1:0] {
      RSY_ST_RUN     = 2'b00,
      RSY_ST_SYS     = 2'b01,
      RSY_ST_ALIGN   = 2'b10,
      RSY_ST_RELEASE = 2'b11
   } rsy_state_t;

   // Register I/O request from the host bus
   typedef struct packed {
      logic        wr;
      logic        rd;
      logic [7:0]  addr;
      logic [15:0] wdata;
   } rsy_io_req_t;

   // DRAM strobe group, all active low
   typedef struct packed {
      logic [3:0] row_n;
      logic [7:0] col_n;
      logic       den_n;
   } rsy_dram_t;

endpackage

`default_nettype wire

//--- logic/rsy_reset_sync.sv
`include "rsy_regs.svh"
`default_nettype none

// Behaviour
// RULE1 - Two async requests become clock-synchronous processor and coprocessor resets.
// RULE2 - Processor-only request asserts processor reset alone; all else keeps state.
// RULE3 - Board holds processor request at least 16 clocks.
// RULE4 - System plus processor request asserts both reset outputs.
// RULE5 - Configuration registers initialise only on system reset.
// RULE6 - Memory configuration register reads zero after system reset.
// RULE7 - Processor busy output driven low during system reset.
// RULE8 - Board holds both requests 80 clocks for valid self-test, else 16.
// RULE9 - Row strobes, column strobes and buffer enable inactive during system reset.
// RULE10 - Error input sampled at system request fall; low means coprocessor present.
// RULE11 - System reset aligns peripheral clock with double-rate clock.
// RULE12 - Sequence: resets, strobes, busy, init, sample, align, then release resets.
// RULE13 - Register writes replace every bit; software writes whole register.
// RULE14 - Software disables shadowing and roll when low DRAM absent.
// RULE15 - Busy released at first address strobe fall, then follows coprocessor busy.
// RULE16 - Peripheral clock held high for alignment; processor reset leaves it alone.
// RULE17 - Each request passes two flip-flops before use.
// RULE18 - Undefined reset bits set to zero; not checked.
module rsy_reset_sync (
   // Clock and reset
   input  wire logic               clock,
   input  wire logic               rst,
   // Board reset requests
   input  wire logic               cpu_reset_request,
   input  wire logic               system_reset_request,
   // Coprocessor and processor bus
   input  wire logic               error_in_n,
   input  wire logic               coproc_busy_in_n,
   input  wire logic               address_strobe_n,
   // Register I/O port
   input  wire rsy_pkg::rsy_io_req_t io_req,
   output logic [15:0]             io_rdata,
   // DRAM strobes from the memory controller and to the pins
   input  wire rsy_pkg::rsy_dram_t  dram_in,
   output rsy_pkg::rsy_dram_t       dram_out,
   // Reset, busy, clock and coprocessor presence outputs
   output logic                    processor_reset_out,
   output logic                    coproc_reset_out,
   output logic                    processor_busy_out_n,
   output logic                    peripheral_clock_n,
   output logic                    coproc_present,
   // Configuration outputs
   output logic [15:0]             memory_configuration,
   output logic                    parity_check_disable
);
   import rsy_pkg::*;

   // =======================================================
   // Request synchronisers
   logic [`RSY_SYNC_STAGES-1:0] cpu_sync_reg;
   logic [`RSY_SYNC_STAGES-1:0] cpu_sync_next;
   logic [`RSY_SYNC_STAGES-1:0] sys_sync_reg;
   logic [`RSY_SYNC_STAGES-1:0] sys_sync_next;
   logic                        cpu_req;
   logic                        sys_req;

   always_comb begin
      cpu_sync_next = {cpu_sync_reg[0], cpu_reset_request};     // RULE17
      sys_sync_next = {sys_sync_reg[0], system_reset_request};  // RULE17
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         cpu_sync_reg <= '0;
         sys_sync_reg <= '0;
      end else begin
         cpu_sync_reg <= cpu_sync_next;
         sys_sync_reg <= sys_sync_next;
      end
   end

   // Only the last stage is used downstream
   assign cpu_req = cpu_sync_reg[`RSY_SYNC_STAGES-1];
   assign sys_req = sys_sync_reg[`RSY_SYNC_STAGES-1];

   // =======================================================
   // System reset sequencer
   rsy_state_t state_reg;
   rsy_state_t state_next;
   logic       present_reg;
   logic       present_next;
   logic       busy_hold_reg;
   logic       busy_hold_next;
   logic       pclk_reg;
   logic       pclk_next;
   logic       ads_prev_reg;
   logic       in_sys;

   assign in_sys = (state_reg == RSY_ST_SYS);

   always_comb begin
      state_next     = state_reg;
      present_next   = present_reg;
      busy_hold_next = busy_hold_reg;
      pclk_next      = ~pclk_reg;
      unique case (state_reg)
         RSY_ST_RUN: begin
            if (sys_req && cpu_req) begin                    // RULE4
               state_next = RSY_ST_SYS;
            end
         end
         RSY_ST_SYS: begin
            busy_hold_next = 1'b1;                           // RULE7
            if (!sys_req) begin
               // Falling edge of the system request
               present_next = ~error_in_n;                   // RULE10
               state_next   = RSY_ST_ALIGN;
            end
         end
         RSY_ST_ALIGN: begin
            pclk_next  = 1'b1;                               // RULE16
            state_next = RSY_ST_RELEASE;                     // RULE12
         end
         RSY_ST_RELEASE: begin
            state_next = RSY_ST_RUN;                         // RULE12
         end
      endcase
      // First address strobe fall after reset ends the self-test hold
      if (state_reg == RSY_ST_RUN && busy_hold_reg &&
          ads_prev_reg && !address_strobe_n) begin
         busy_hold_next = 1'b0;                              // RULE15
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         state_reg     <= RSY_ST_RUN;
         present_reg   <= 1'b0;
         busy_hold_reg <= 1'b1;
         pclk_reg      <= 1'b1;
         ads_prev_reg  <= 1'b1;
      end else begin
         state_reg     <= state_next;
         present_reg   <= present_next;
         busy_hold_reg <= busy_hold_next;
         pclk_reg      <= pclk_next;                         // RULE11
         ads_prev_reg  <= address_strobe_n;
      end
   end

   // =======================================================
   // Reset, busy and strobe outputs
   logic               cpu_rst_reg;
   logic               cpu_rst_next;
   logic               npx_rst_reg;
   logic               npx_rst_next;
   logic               busy_reg;
   logic               busy_next;
   rsy_dram_t          dram_reg;
   rsy_dram_t          dram_next;

   always_comb begin
      // Processor-only request touches nothing but this output
      cpu_rst_next = cpu_req || (state_reg != RSY_ST_RUN);   // RULE1 RULE2
      npx_rst_next = (state_reg != RSY_ST_RUN);              // RULE1 RULE4
      // After the hold, without a coprocessor the busy line is left inactive
      if (busy_hold_next) begin
         busy_next = 1'b0;                                   // RULE7
      end else begin
         busy_next = present_reg ? coproc_busy_in_n : 1'b1;  // RULE15
      end
      if (in_sys || state_next == RSY_ST_SYS) begin
         dram_next = '1;                                     // RULE9
      end else begin
         dram_next = dram_in;
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         cpu_rst_reg <= 1'b1;
         npx_rst_reg <= 1'b1;
         busy_reg    <= 1'b0;
         dram_reg    <= '1;
      end else begin
         cpu_rst_reg <= cpu_rst_next;
         npx_rst_reg <= npx_rst_next;
         busy_reg    <= busy_next;
         dram_reg    <= dram_next;
      end
   end

   // =======================================================
   // Configuration registers
   function automatic logic [3:0] reg_index(input logic [7:0] addr);
      logic [3:0] idx;
      idx = 4'hf;
      unique case (addr)
         `RSY_OFF_MEM_CFG:     idx = {1'b0, `RSY_IDX_MEM_CFG};
         `RSY_OFF_ROLL_ONE:    idx = {1'b0, `RSY_IDX_ROLL_ONE};
         `RSY_OFF_ROLL_TWO:    idx = {1'b0, `RSY_IDX_ROLL_TWO};
         `RSY_OFF_REGION_ZERO: idx = {1'b0, `RSY_IDX_REGION_ZERO};
         `RSY_OFF_REGION_ONE:  idx = {1'b0, `RSY_IDX_REGION_ONE};
         `RSY_OFF_GRAN_EN:     idx = {1'b0, `RSY_IDX_GRAN_EN};
         `RSY_OFF_EXT_GRAN:    idx = {1'b0, `RSY_IDX_EXT_GRAN};
         default:              idx = 4'hf;
      endcase
      return idx;
   endfunction

   localparam logic [15:0] RST_VALS [`RSY_NUM_REGS] = '{
      `RSY_RST_MEM_CFG, `RSY_RST_ROLL_ONE, `RSY_RST_ROLL_TWO,
      `RSY_RST_REGION_ZERO, `RSY_RST_REGION_ONE, `RSY_RST_GRAN_EN,
      `RSY_RST_EXT_GRAN};

   logic [15:0] cfg_reg  [`RSY_NUM_REGS];
   logic [15:0] cfg_next [`RSY_NUM_REGS];
   logic        par_reg;
   logic        par_next;
   logic [15:0] rdata_reg;
   logic [15:0] rdata_next;
   logic [3:0]  idx;

   always_comb begin
      idx      = reg_index(io_req.addr);
      cfg_next = cfg_reg;
      par_next = par_reg;
      rdata_next = rdata_reg;
      // Init wins over writes while the system reset is running
      if (in_sys) begin
         cfg_next = RST_VALS;                                // RULE5 RULE6 RULE18
         par_next = `RSY_RST_PARITY;                         // RULE5
      end else if (io_req.wr) begin
         if (idx != 4'hf) begin
            cfg_next[idx[2:0]] = io_req.wdata;               // RULE13
         end
         if (io_req.addr == `RSY_OFF_PARITY) begin
            par_next = io_req.wdata[`RSY_PARITY_BIT];
         end
      end
      // Parity port is write-only; it and unmapped ports read zero
      if (io_req.rd) begin
         rdata_next = (idx != 4'hf) ? cfg_reg[idx[2:0]] : 16'h0000;
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         cfg_reg   <= RST_VALS;
         par_reg   <= `RSY_RST_PARITY;
         rdata_reg <= 16'h0000;
      end else begin
         cfg_reg   <= cfg_next;
         par_reg   <= par_next;
         rdata_reg <= rdata_next;
      end
   end

   // =======================================================
   // Output drive
   assign processor_reset_out  = cpu_rst_reg;
   assign coproc_reset_out     = npx_rst_reg;
   assign processor_busy_out_n = busy_reg;
   assign peripheral_clock_n   = pclk_reg;
   assign coproc_present       = present_reg;
   assign dram_out             = dram_reg;
   assign io_rdata             = rdata_reg;
   assign memory_configuration = cfg_reg[`RSY_IDX_MEM_CFG];
   assign parity_check_disable = par_reg;

endmodule

`default_nettype wire

//--- verification/rsy_reset_sync_chk.sv
`default_nettype none
module rsy_reset_sync_chk (
   // Clock, reset and inputs
   input wire logic                 clock,
   input wire logic                 rst,
   input wire logic                 cpu_reset_request,
   input wire logic                 system_reset_request,
   input wire logic                 error_in_n,
   input wire logic                 coproc_busy_in_n,
   input wire logic                 address_strobe_n,
   input wire rsy_pkg::rsy_io_req_t io_req,
   // Outputs
   input wire rsy_pkg::rsy_dram_t   dram_out,
   input wire logic                 processor_reset_out,
   input wire logic                 coproc_reset_out,
   input wire logic                 processor_busy_out_n,
   input wire logic                 peripheral_clock_n,
   input wire logic                 coproc_present,
   input wire logic [15:0]          memory_configuration
);
   timeunit 1ns;
   timeprecision 100ps;
   import rsy_pkg::*;
   default clocking @(posedge clock); endclocking
   default disable iff (rst);
   // ==========================================================
   // Request shapes
   sequence both_held;
      system_reset_request && cpu_reset_request;
   endsequence
   sequence cpu_alone;
      cpu_reset_request && !system_reset_request && !coproc_reset_out;
   endsequence
   // ==========================================================
   // Properties
   cpu_sync_a: assert property (
      $rose(cpu_reset_request) |=> !processor_reset_out ##[1:3]
      processor_reset_out) else $error("processor reset timing");
   cpu_only_a: assert property (
      (!system_reset_request)[*8] |-> !coproc_reset_out)
      else $error("coprocessor reset without system request");
   sys_both_a: assert property (
      both_held[*6] |-> processor_reset_out && coproc_reset_out)
      else $error("system reset missing an output");
   busy_low_a: assert property (
      coproc_reset_out |-> !processor_busy_out_n)
      else $error("busy not low in system reset");
   dram_off_a: assert property (
      coproc_reset_out && system_reset_request |-> dram_out == '1)
      else $error("strobes active in system reset");
   cfg_keep_a: assert property (
      cpu_alone and !io_req.wr |=> $stable(memory_configuration))
      else $error("config changed by processor reset");
   cfg_zero_a: assert property (
      $fell(coproc_reset_out) |-> memory_configuration == 16'h0000)
      else $error("config not cleared");
   coproc_seen_a: assert property (
      $fell(system_reset_request) |-> ##5 coproc_present == !error_in_n)
      else $error("coprocessor presence wrong");
   pclk_run_a: assert property (
      !coproc_reset_out && !$past(coproc_reset_out) |->
      peripheral_clock_n != $past(peripheral_clock_n))
      else $error("peripheral clock stalled");
   busy_follow_a: assert property (
      !coproc_reset_out && $fell(address_strobe_n) |=> processor_busy_out_n
      == (coproc_present ? $past(coproc_busy_in_n) : 1'b1))
      else $error("busy does not follow");
endmodule
bind rsy_reset_sync rsy_reset_sync_chk chk (.*);
`default_nettype wire

//--- verification/rsy_board_model.sv
`default_nettype none
module rsy_board_model (
   // Commands from the bench
   input wire logic  clock,
   input wire logic  start_cpu,
   input wire logic  start_sys,
   input wire logic  fitted,
   input wire logic  npx_busy,
   // Board and coprocessor lines
   output var logic  cpu_reset_request,
   output var logic  system_reset_request,
   output var logic  error_in_n,
   output var logic  coproc_busy_in_n
);
   timeunit 1ns;
   timeprecision 100ps;
   int unsigned left = 0;
   logic        sys = 1'b0;
   // Pull-ups leave both lines high with no coprocessor
   assign error_in_n = !fitted;
   assign coproc_busy_in_n = fitted ? !npx_busy : 1'b1;
   assign cpu_reset_request = (left != 0);
   assign system_reset_request = sys && (left != 0);
   always @(posedge clock) begin
      if (start_sys) begin
         left <= 80;
         sys <= 1'b1;
      end else if (start_cpu) begin
         left <= 16;
         sys <= 1'b0;
      end else if (left != 0) begin
         left <= left - 1;
      end
   end
endmodule
`default_nettype wire

//--- verification/rsy_reset_sync_tb.sv
`default_nettype none
`define CHK(nm, ex, gt) \
   begin \
      num_checks++; \
      if ((gt) !== (ex)) begin \
         err_total++; \
         $display("FAIL %s exp %h got %h", nm, ex, gt); \
      end \
   end
module rsy_reset_sync_tb;
   timeunit 1ns;
   timeprecision 100ps;
   import rsy_pkg::*;
   logic        clock = 1'b0;
   logic        rst = 1'b1;
   logic        ads_n = 1'b1;
   logic        start_cpu = 1'b0;
   logic        start_sys = 1'b0;
   logic        fitted = 1'b1;
   logic        npx_busy = 1'b0;
   logic        cpu_rq, sys_rq, err_n, bsy_n, prst, crst, busy_n;
   logic        pclk_n, present, par_dis, ph0, ph1;
   rsy_io_req_t io_req = '0;
   rsy_dram_t   dram_in = 13'h0a5a;
   rsy_dram_t   dram_out;
   logic [15:0] io_rdata, mem_cfg;
   int          err_total = 0;
   int          num_checks = 0;
   rsy_board_model board (.clock(clock), .start_cpu(start_cpu),
      .start_sys(start_sys), .fitted(fitted), .npx_busy(npx_busy),
      .cpu_reset_request(cpu_rq), .system_reset_request(sys_rq),
      .error_in_n(err_n), .coproc_busy_in_n(bsy_n));
   rsy_reset_sync uut (.clock(clock), .rst(rst),
      .cpu_reset_request(cpu_rq), .system_reset_request(sys_rq),
      .error_in_n(err_n), .coproc_busy_in_n(bsy_n),
      .address_strobe_n(ads_n), .io_req(io_req), .io_rdata(io_rdata),
      .dram_in(dram_in), .dram_out(dram_out), .processor_reset_out(prst),
      .coproc_reset_out(crst), .processor_busy_out_n(busy_n),
      .peripheral_clock_n(pclk_n), .coproc_present(present),
      .memory_configuration(mem_cfg), .parity_check_disable(par_dis));
   // ==========================================================
   // Bus helpers
   task automatic tick(input int n = 1);
      repeat (n) @(posedge clock);
      #1;
   endtask
   task automatic io_wr(input logic [7:0] a, input logic [15:0] d);
      io_req = '{1'b1, 1'b0, a, d};
      tick();
      io_req = '0;
      tick();
   endtask
   task automatic io_rd(input logic [7:0] a, output logic [15:0] d);
      io_req = '{1'b0, 1'b1, a, 16'h0000};
      tick();
      io_req = '0;
      tick();
      d = io_rdata;
   endtask
   // ==========================================================
   // Scenarios
   task automatic t_regs;
      logic [15:0] d;
      io_rd(8'h22, d);
      `CHK("mem_cfg", 16'h0000, d)
      io_rd(8'h2c, d);
      `CHK("gran_en", 16'h0000, d)
      io_rd(8'h2e, d);
      `CHK("ext_gran", 16'h0000, d)
      // No low DRAM on this bench, so the roll enable bit stays clear
      io_wr(8'h24, 16'h7ffe);
      io_rd(8'h24, d);
      `CHK("roll one", 16'h7ffe, d)
      io_wr(8'h22, 16'hffff);
      io_wr(8'h22, 16'h0001);
      io_rd(8'h22, d);
      `CHK("whole word", 16'h0001, d)
      io_wr(8'h61, 16'h0004);
      io_rd(8'h61, d);
      `CHK("parity read", 16'h0000, d)
      `CHK("parity bit", 1'b1, par_dis)
   endtask
   task automatic t_cpu;
      io_wr(8'h22, 16'h5a3c);
      start_cpu = 1'b1;
      tick();
      start_cpu = 1'b0;
      for (int i = 0; i < 50 && prst !== 1'b1; i++) tick();
      `CHK("cpu reset", 2'b10, {prst, crst})
      `CHK("strobes kept", 13'h0a5a, dram_out)
      for (int i = 0; i < 50 && prst !== 1'b0; i++) tick();
      `CHK("cfg kept", 16'h5a3c, mem_cfg)
      `CHK("parity kept", 1'b1, par_dis)
   endtask
   task automatic t_sys(input logic fit, output logic ph);
      fitted = fit;
      io_wr(8'h22, 16'hbeef);
      start_sys = 1'b1;
      tick();
      start_sys = 1'b0;
      for (int i = 0; i < 50 && crst !== 1'b1; i++) tick();
      `CHK("both resets", 2'b11, {prst, crst})
      `CHK("strobes off", 13'h1fff, dram_out)
      `CHK("busy low", 1'b0, busy_n)
      for (int i = 0; i < 200 && crst !== 1'b0; i++) tick();
      ph = pclk_n;
      `CHK("cpu released", 1'b0, prst)
      `CHK("strobes pass", 13'h0a5a, dram_out)
      `CHK("cfg init", 16'h0000, mem_cfg)
      `CHK("parity init", 1'b0, par_dis)
      `CHK("present", fit, present)
      `CHK("busy held", 1'b0, busy_n)
      npx_busy = 1'b1;
      ads_n = 1'b0;
      tick();
      ads_n = 1'b1;
      tick();
      `CHK("busy follow", !fit, busy_n)
      npx_busy = 1'b0;
      tick(2);
      `CHK("busy idle", 1'b1, busy_n)
   endtask
   task automatic summarize;
      $display("checks %0d errors %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   // ==========================================================
   // Clock, watchdog and main sequence
   initial begin
      forever #5 clock = ~clock;
   end
   // Whole run is under a thousand cycles; five times that is a hang
   initial begin
      #50000;
      err_total++;
      summarize();
   end
   initial begin
      tick(20);
      rst = 1'b0;
      tick(3);
      t_regs();
      t_cpu();
      t_sys(1'b1, ph0);
      t_sys(1'b0, ph1);
      `CHK("clock phase", ph0, ph1)
      `CHK("phase at release", 1'b1, ph0)
      summarize();
   end
endmodule
`default_nettype wire
